/* hdl/ebcs_top.sv */
`timescale 1ns/1ps
`include "ebcs_params.svh"
// Summary of operation
// - external bus roles only in expansion or microprocessor mode
// - twenty-four address lines cover sixteen megabytes
// - top address line is the inverted address msb
// - each area picks eight or sixteen bit data bus
// - after reset area 3 width follows the byte pin, high is eight bit
// - address undefined after leaving single chip until first external access
// - dram access puts row then column on a8 to a20
// - area mode field picks select pins and select ranges, format picks address pins
// - area mode resets to mode 0
// - up to four active low selects
// - select falls in the same cycle as its address appears
// - select stays until the next access picks another region or single chip mode is entered
// - format resets separate, all-space multiplex refused in microprocessor mode
// - outside dram access, all-space multiplex outputs only the low sixteen address bits
// - port 4 upper pins carry selects or a20 to a23
// - dram access turns port 5 pins into column and write strobes
// - multiplexed pins carry address only for multiplexed-bus areas
// - two-bit field routes the address latch strobe to a pin
// - mode 3 selects each cover one megabyte
// - two-bit field chooses separate or multiplexed format
// - width bit zero is eight bit, one is sixteen bit
module ebcs_top (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [1:0] proc_mode_in,
  input wire logic cfg_load_in,
  input wire logic [1:0] area_mode_in,
  input wire logic [1:0] bus_format_in,
  input wire logic [3:0] width_ctrl_in,
  input wire logic [1:0] ale_sel_in,
  input wire logic dram_en_in,
  input wire logic byte_pin_in,
  input wire logic acc_valid_in,
  input wire logic [23:0] acc_addr_in,
  input wire logic acc_write_in,
  output logic acc_ready_out,
  output logic ext_active_out,
  output logic [22:0] addr_out,
  output logic inverted_top_address_out,
  output logic area_select_0_n_out,
  output logic area_select_1_n_out,
  output logic area_select_2_n_out,
  output logic area_select_3_n_out,
  output logic [3:0] p4_cs_role_out,
  output logic p4_addr_role_out,
  output logic p0_data_role_out,
  output logic p1_data_role_out,
  output logic p2_mux_out,
  output logic p3_mux_out,
  output logic [2:0] ale_out,
  output logic dram_role_out,
  output logic column_strobe_low_out,
  output logic column_strobe_high_out,
  output logic dram_write_strobe_out,
  output logic addr_valid_out,
  output logic [1:0] area_mode_out,
  output logic [1:0] bus_format_out,
  output logic [3:0] width_out
);
  import ebcs_pkg::*;

  // ****************************************
  // helpers
  // ****************************************

  // address as driven on the pins for a format
  function automatic logic [23:0] pin_addr(input logic [23:0] a, input logic [1:0] fmt);
    pin_addr = a;
    if (fmt == `EBCS_FMT_ALL) pin_addr = {8'h00, a[`EBCS_LOW16_MSB:0]};
  endfunction

  // one-hot latch strobe pin
  function automatic logic [2:0] ale_pin(input logic [1:0] sel);
    case (sel)
      2'h0: ale_pin = 3'h1;
      2'h1: ale_pin = 3'h2;
      2'h2: ale_pin = 3'h4;
      default: ale_pin = 3'h0;
    endcase
  endfunction

  ebcs_reg_t r;
  ebcs_reg_t n;
  logic byte_s;
  logic ext;
  logic micro;
  logic [3:0] cs_hit;
  logic [1:0] area;
  logic hit;
  logic dram;
  logic accept;
  logic mux;

  // ****************************************
  // input conditioning and decode
  // ****************************************

  // byte pin comes from outside
  ebcs_sync3 u_byte_sync (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(byte_pin_in),
    .level_out(byte_s)
  );

  ebcs_cs_decode u_dec (
    .addr_in(acc_addr_in),
    .amode_in(r.amode),
    .micro_in(micro),
    .dram_en_in(dram_en_in),
    .cs_out(cs_hit),
    .area_out(area),
    .hit_out(hit),
    .dram_out(dram)
  );

  // mode and acceptance terms
  always_comb begin
    ext = (proc_mode_in != `EBCS_PM_SINGLE);
    micro = (proc_mode_in == `EBCS_PM_MICRO);
    accept = acc_valid_in && r.ready && ext && hit;
    mux = (r.fmt == `EBCS_FMT_ALL) || ((r.fmt == `EBCS_FMT_CS12) && (area <= 2'h1));
  end

  // ****************************************
  // next state
  // ****************************************

  always_comb begin
    n = r;
    n.ext = ext;
    n.ale = 3'h0;
    // area 3 width follows byte pin
    if (!r.strap_done) n.width[3] = !byte_s;
    if (cfg_load_in) begin
      n.amode = area_mode_in;
      n.width = width_ctrl_in;
      n.ale_sel = ale_sel_in;
      n.strap_done = 1'b1;
      if (!(micro && (bus_format_in == `EBCS_FMT_ALL))) n.fmt = bus_format_in;
    end
    // leaving it on entry to microprocessor mode
    if (micro && (n.fmt == `EBCS_FMT_ALL)) n.fmt = `EBCS_FMT_SEP;
    case (r.st)
      EBCS_IDLE: begin
        if (accept) begin
          n.cur = acc_addr_in;
          n.cur_wr = acc_write_in;
          n.area = area;
          n.known = 1'b1;
          // release decided by this next access
          n.cs_n = ~cs_hit;
          n.addr = pin_addr(acc_addr_in, r.fmt);
          n.addr[23] = !n.addr[23];
          n.p2_mux = mux && !dram;
          // width bit one adds high byte
          n.p3_mux = mux && !dram && r.width[area];
          if (dram) begin
            n.addr[`EBCS_DRAM_MSB:`EBCS_DRAM_LSB] =
              acc_addr_in[`EBCS_ROW_MSB:`EBCS_ROW_LSB];
            n.dram_role = 1'b1;
            n.st = EBCS_ROW;
          end else if (mux) begin
            n.ale = ale_pin(r.ale_sel);
          end
        end
      end
      EBCS_ROW: begin
        n.addr[`EBCS_DRAM_MSB:`EBCS_DRAM_LSB] = {4'h0, r.cur[`EBCS_COL_MSB:0]};
        n.cas_l = 1'b1;
        n.cas_h = r.width[r.area];
        n.dw = r.cur_wr;
        n.st = EBCS_COL;
      end
      EBCS_COL: begin
        n.cas_l = 1'b0;
        n.cas_h = 1'b0;
        n.dw = 1'b0;
        n.dram_role = 1'b0;
        n.st = EBCS_IDLE;
      end
      default: begin
        n.st = EBCS_IDLE;
        n.dram_role = 1'b0;
      end
    endcase
    n.ready = (n.st == EBCS_IDLE);
    // port 4 pin roles by area mode and format
    // mode picks selects, format picks address pins
    n.p4_cs = ebcs_cs_roles(n.amode);
    n.p4_addr = (n.fmt != `EBCS_FMT_ALL);
    n.p0_data = (n.fmt != `EBCS_FMT_ALL);
    n.p1_data = (n.fmt != `EBCS_FMT_ALL) && (|n.width);
    // single chip leaves every pin a port
    if (!ext) begin
      n.p4_cs = 4'h0;
      n.p4_addr = 1'b0;
      n.p0_data = 1'b0;
      n.p1_data = 1'b0;
      n.p2_mux = 1'b0;
      n.p3_mux = 1'b0;
      n.cs_n = 4'hF;
      n.known = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************

  // area mode 0 and separate bus at reset
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '0;
      r.st <= EBCS_IDLE;
      r.amode <= `EBCS_AM0;
      r.fmt <= `EBCS_FMT_SEP;
      r.ale_sel <= `EBCS_ALE_NONE;
      r.cs_n <= 4'hF;
      r.addr[23] <= 1'b1;
      r.ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  // pins straight from state
  always_comb begin
    acc_ready_out = r.ready;
    ext_active_out = r.ext;
    addr_out = r.addr[22:0];
    inverted_top_address_out = r.addr[23];
    area_select_0_n_out = r.cs_n[0];
    area_select_1_n_out = r.cs_n[1];
    area_select_2_n_out = r.cs_n[2];
    area_select_3_n_out = r.cs_n[3];
    p4_cs_role_out = r.p4_cs;
    p4_addr_role_out = r.p4_addr;
    p0_data_role_out = r.p0_data;
    p1_data_role_out = r.p1_data;
    p2_mux_out = r.p2_mux;
    p3_mux_out = r.p3_mux;
    ale_out = r.ale;
    dram_role_out = r.dram_role;
    column_strobe_low_out = r.cas_l;
    column_strobe_high_out = r.cas_h;
    dram_write_strobe_out = r.dw;
    addr_valid_out = r.known;
    area_mode_out = r.amode;
    bus_format_out = r.fmt;
    width_out = r.width;
  end

  // ****************************************
  // checks
  // ****************************************

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_single_chip;
    !ext |=> (p4_cs_role_out == 4'h0) && !p0_data_role_out && !p2_mux_out && !addr_valid_out;
  endproperty
  a_single_chip: assert property (p_single_chip) else $error("bus role in single chip");

  property p_inv_top;
    accept && !dram && (r.fmt != `EBCS_FMT_ALL) |=>
      (inverted_top_address_out == !$past(acc_addr_in[23])) &&
      (addr_out == $past(acc_addr_in[22:0]));
  endproperty
  a_inv_top: assert property (p_inv_top) else $error("top line not inverted");

  property p_strap;
    !r.strap_done && !cfg_load_in |=> width_out[3] == !$past(byte_s);
  endproperty
  a_strap: assert property (p_strap) else $error("area 3 width not from byte pin");

  property p_cs_with_addr;
    accept && ext |=> ({area_select_3_n_out, area_select_2_n_out,
      area_select_1_n_out, area_select_0_n_out} == ~$past(cs_hit)) && addr_valid_out;
  endproperty
  a_cs_with_addr: assert property (p_cs_with_addr) else $error("select late");

  property p_cs_hold;
    ext && $past(ext) && !accept |=> $stable(r.cs_n);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("select released early");

  property p_dram_seq;
    accept && dram && ext |=> dram_role_out && !acc_ready_out ##1
      column_strobe_low_out ##1 acc_ready_out && !column_strobe_low_out;
  endproperty
  a_dram_seq: assert property (p_dram_seq) else $error("dram row column order");

  property p_no_all_micro;
    micro && $past(micro) |-> r.fmt != `EBCS_FMT_ALL;
  endproperty
  a_no_all_micro: assert property (p_no_all_micro) else $error("all multiplex in micro");

  property p_low16;
    accept && (r.fmt == `EBCS_FMT_ALL) |=> addr_out[22:16] == 7'h00;
  endproperty
  a_low16: assert property (p_low16) else $error("upper address driven");

  property p_ale;
    accept && mux && !dram && (r.ale_sel == 2'h1) |=> ale_out == 3'h2 ##1
      ((ale_out == 3'h0) || $past(accept));
  endproperty
  a_ale: assert property (p_ale) else $error("latch strobe pin wrong");

  property p_one_cs;
    $onehot0(~r.cs_n);
  endproperty
  a_one_cs: assert property (p_one_cs) else $error("two selects low");

  c_dram: cover property (accept && dram ##2 column_strobe_low_out);
  c_mux: cover property (accept && mux ##1 p2_mux_out);
  c_reject: cover property (cfg_load_in && micro && (bus_format_in == `EBCS_FMT_ALL));
  c_mode3_cs3: cover property (accept && (r.amode == `EBCS_AM3) && cs_hit[3]);
endmodule

/* hdl/ebcs_params.svh */
`ifndef EBCS_PARAMS_SVH
`define EBCS_PARAMS_SVH
// processor modes
`define EBCS_PM_SINGLE 2'h0
`define EBCS_PM_EXP 2'h1
`define EBCS_PM_MICRO 2'h3
// bus formats
`define EBCS_FMT_SEP 2'h0
`define EBCS_FMT_CS12 2'h1
`define EBCS_FMT_ALL 2'h3
// external area modes
`define EBCS_AM0 2'h0
`define EBCS_AM1 2'h1
`define EBCS_AM2 2'h2
`define EBCS_AM3 2'h3
// cs pin roles per area mode, bit i is select i
`define EBCS_ROLE_AM0 4'h0
`define EBCS_ROLE_AM1 4'h7
`define EBCS_ROLE_AM2 4'h3
`define EBCS_ROLE_AM3 4'hF
// ale pin selection, none
`define EBCS_ALE_NONE 2'h3
// region bounds
`define EBCS_R0_LO 24'h00_8000
`define EBCS_R0_HI 24'h1F_FFFF
`define EBCS_R1_LO 24'h20_0000
`define EBCS_R1_HI 24'h3F_FFFF
`define EBCS_R2_LO 24'h40_0000
`define EBCS_R2_HI 24'hBF_FFFF
`define EBCS_R3_LO 24'hC0_0000
`define EBCS_M1_CS0_HI 24'hDF_FFFF
`define EBCS_R3_HI_EXP 24'hEF_FFFF
`define EBCS_CS0_E_LO 24'hE0_0000
`define EBCS_M3_CS0_LO 24'hF0_0000
`define EBCS_TOP 24'hFF_FFFF
`define EBCS_M3_CS1_LO 24'h10_0000
`define EBCS_M3_CS2_HI 24'h2F_FFFF
`define EBCS_M3_CS3_HI 24'hCF_FFFF
// dram row and column fields on a8..a20
`define EBCS_ROW_MSB 21
`define EBCS_ROW_LSB 9
`define EBCS_COL_MSB 8
`define EBCS_DRAM_LSB 8
`define EBCS_DRAM_MSB 20
`define EBCS_LOW16_MSB 15
`endif

/* hdl/ebcs_pkg.sv */
`include "ebcs_params.svh"
package ebcs_pkg;
  typedef enum logic [2:0] {
    EBCS_IDLE = 3'h1,
    EBCS_ROW = 3'h2,
    EBCS_COL = 3'h4
  } ebcs_state_t;

  typedef struct packed {
    ebcs_state_t st;
    logic [1:0] amode;
    logic [1:0] fmt;
    logic [3:0] width;
    logic [1:0] ale_sel;
    logic strap_done;
    logic [23:0] addr;
    logic [23:0] cur;
    logic cur_wr;
    logic [1:0] area;
    logic [3:0] cs_n;
    logic [2:0] ale;
    logic ready;
    logic ext;
    logic known;
    logic [3:0] p4_cs;
    logic p0_data;
    logic p1_data;
    logic p4_addr;
    logic p2_mux;
    logic p3_mux;
    logic dram_role;
    logic cas_l;
    logic cas_h;
    logic dw;
  } ebcs_reg_t;

  // pins that carry selects for an area mode
  function automatic logic [3:0] ebcs_cs_roles(input logic [1:0] amode);
    case (amode)
      `EBCS_AM1: ebcs_cs_roles = `EBCS_ROLE_AM1;
      `EBCS_AM2: ebcs_cs_roles = `EBCS_ROLE_AM2;
      `EBCS_AM3: ebcs_cs_roles = `EBCS_ROLE_AM3;
      default: ebcs_cs_roles = `EBCS_ROLE_AM0;
    endcase
  endfunction
endpackage

/* hdl/ebcs_sync3.sv */
`timescale 1ns/1ps
// three stage pin synchroniser, change taken when stages 2 and 3 agree
module ebcs_sync3 (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } ebcs_sync_t;

  ebcs_sync_t r;
  ebcs_sync_t n;

  // stage chain and agreement filter
  always_comb begin
    n = r;
    n.s1 = pin_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) n.level = r.s3;
  end

  // stage registers
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // filtered level straight from its flop
  assign level_out = r.level;
endmodule

/* hdl/ebcs_cs_decode.sv */
`timescale 1ns/1ps
`include "ebcs_params.svh"
// address to external area and chip select decoder
module ebcs_cs_decode (
  input wire logic [23:0] addr_in,
  input wire logic [1:0] amode_in,
  input wire logic micro_in,
  input wire logic dram_en_in,
  output logic [3:0] cs_out,
  output logic [1:0] area_out,
  output logic hit_out,
  output logic dram_out
);
  import ebcs_pkg::*;

  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  logic [3:0] h;
  logic [23:0] lo0;
  logic [23:0] hi0;

  // area 3 bounds per mode
  always_comb begin
    case (amode_in)
      `EBCS_AM1: begin
        lo0 = micro_in ? `EBCS_CS0_E_LO : `EBCS_R3_LO;
        hi0 = micro_in ? `EBCS_TOP : `EBCS_M1_CS0_HI;
      end
      `EBCS_AM3: begin
        lo0 = micro_in ? `EBCS_M3_CS0_LO : `EBCS_CS0_E_LO;
        hi0 = micro_in ? `EBCS_TOP : `EBCS_R3_HI_EXP;
      end
      default: begin
        lo0 = `EBCS_R3_LO;
        hi0 = micro_in ? `EBCS_TOP : `EBCS_R3_HI_EXP;
      end
    endcase
  end

  // compare against bounds of active mode
  always_comb begin
    h[0] = in_rng(addr_in, (amode_in == `EBCS_AM3) ? `EBCS_M3_CS1_LO : `EBCS_R0_LO,
                  `EBCS_R0_HI);
    h[1] = (amode_in != `EBCS_AM2) && in_rng(addr_in, `EBCS_R1_LO,
           (amode_in == `EBCS_AM3) ? `EBCS_M3_CS2_HI : `EBCS_R1_HI);
    h[2] = (amode_in == `EBCS_AM3) ? in_rng(addr_in, `EBCS_R3_LO, `EBCS_M3_CS3_HI)
                                   : in_rng(addr_in, `EBCS_R2_LO, `EBCS_R2_HI);
    h[3] = in_rng(addr_in, lo0, hi0);
    hit_out = |h;
    area_out = h[3] ? 2'h3 : h[2] ? 2'h2 : h[1] ? 2'h1 : 2'h0;
    // select i maps to area (i+3) mod 4
    cs_out = {h[2], h[1], h[0], h[3]} & ebcs_cs_roles(amode_in);
    dram_out = h[2] && dram_en_in && (amode_in != `EBCS_AM3);
  end
endmodule

/* verification/ebcs_ext_mem.sv */
`timescale 1ns/1ps
// ***********************************
// external device seen from the pins
// ***********************************
module ebcs_ext_mem (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] select_n_in,
  input wire logic [22:0] addr_in,
  input wire logic top_n_in,
  output logic [23:0] seen_addr_out,
  output logic [3:0] seen_sel_out
);
  // latch the full address while any device is selected
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      seen_addr_out <= 24'h00_0000;
      seen_sel_out <= 4'hF;
    end else if (select_n_in != 4'hF) begin
      seen_addr_out <= {~top_n_in, addr_in};
      seen_sel_out <= select_n_in;
    end
  end
endmodule

/* verification/ebcs_top_test.sv */
`timescale 1ns/1ps
module ebcs_top_test;
  import ebcs_pkg::*;
  logic ref_clk, rst_b, cfg_load, dram_en, byte_pin, acc_valid, acc_write;
  logic [1:0] proc_mode, area_mode, bus_format, ale_sel, amode_o, fmt_o;
  logic [3:0] width_ctrl, sel_n, p4_cs, width_o, seen_sel;
  logic [23:0] acc_addr, seen_addr;
  logic [22:0] addr;
  logic [2:0] ale;
  logic acc_ready, ext_active, top_n, p4_addr, p0_data, p1_data, p2_mux, p3_mux;
  logic dram_role, cas_l, cas_h, dram_wr, addr_valid;
  int err_count, comparisons;
  logic [23:0] ta [4] = '{24'h10_0000, 24'h2F_FFFF, 24'hC0_0000, 24'hE0_0000};
  logic [3:0] ts [4] = '{4'hD, 4'hB, 4'h7, 4'hE};
  localparam logic [23:0] DA = 24'h4A_BCDE;

  ebcs_top u_dut (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .proc_mode_in(proc_mode),
    .cfg_load_in(cfg_load), .area_mode_in(area_mode), .bus_format_in(bus_format),
    .width_ctrl_in(width_ctrl), .ale_sel_in(ale_sel), .dram_en_in(dram_en),
    .byte_pin_in(byte_pin), .acc_valid_in(acc_valid), .acc_addr_in(acc_addr),
    .acc_write_in(acc_write), .acc_ready_out(acc_ready), .ext_active_out(ext_active),
    .addr_out(addr), .inverted_top_address_out(top_n), .area_select_0_n_out(sel_n[0]),
    .area_select_1_n_out(sel_n[1]), .area_select_2_n_out(sel_n[2]),
    .area_select_3_n_out(sel_n[3]), .p4_cs_role_out(p4_cs), .p4_addr_role_out(p4_addr),
    .p0_data_role_out(p0_data), .p1_data_role_out(p1_data), .p2_mux_out(p2_mux),
    .p3_mux_out(p3_mux), .ale_out(ale), .dram_role_out(dram_role),
    .column_strobe_low_out(cas_l), .column_strobe_high_out(cas_h),
    .dram_write_strobe_out(dram_wr), .addr_valid_out(addr_valid),
    .area_mode_out(amode_o), .bus_format_out(fmt_o), .width_out(width_o));

  ebcs_ext_mem u_mem (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .select_n_in(sel_n),
    .addr_in(addr), .top_n_in(top_n), .seen_addr_out(seen_addr), .seen_sel_out(seen_sel));

  // ***********************************
  // tasks
  // ***********************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one config load pulse, outputs settle one cycle later
  task automatic cfg(input logic [1:0] am, fm, al, input logic [3:0] w);
    @(posedge ref_clk);
    cfg_load <= 1'b1;
    area_mode <= am;
    bus_format <= fm;
    ale_sel <= al;
    width_ctrl <= w;
    @(posedge ref_clk);
    cfg_load <= 1'b0;
    #1;
  endtask

  // one access request, sampled just after the taking edge
  task automatic acc(input logic [23:0] a, input logic wr);
    int n;
    n = 0;
    @(posedge ref_clk);
    while (acc_ready !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20) begin
      err_count++;
      $display("FAIL at %0t: ready timeout", $time);
    end
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_write <= wr;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    #1;
  endtask

  task automatic mode(input logic [1:0] m);
    @(posedge ref_clk);
    proc_mode <= m;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic done(input string name);
    $display("test %s done, mismatches so far %0d", name, err_count);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ***********************************
  // clock, watchdog and test sequence
  // ***********************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // whole sequence needs about 70 cycles
  initial begin
    #20000;
    err_count++;
    $display("FAIL at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    proc_mode = 2'h0;
    cfg_load = 1'b0;
    area_mode = 2'h0;
    bus_format = 2'h0;
    width_ctrl = 4'h0;
    ale_sel = 2'h3;
    dram_en = 1'b0;
    byte_pin = 1'b1;
    acc_valid = 1'b0;
    acc_addr = 24'h00_0000;
    acc_write = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk(sel_n, 4'hF, "selects idle");
    chk(top_n, 1'b1, "top line idle");
    chk(amode_o, 2'h0, "area mode reset");
    chk(fmt_o, 2'h0, "format reset");
    repeat (6) @(posedge ref_clk);
    #1;
    chk(width_o[3], 1'b0, "byte pin high gives 8 bit");
    done("reset");
    acc(24'h10_0000, 1'b0);
    chk(sel_n, 4'hF, "single chip select");
    chk({ext_active, p4_cs, p0_data}, 6'h00, "single chip roles");
    done("single_chip");
    mode(2'h1);
    chk(ext_active, 1'b1, "expansion drives bus");
    cfg(2'h3, 2'h0, 2'h3, 4'h0);
    chk(p4_cs, 4'hF, "mode 3 pin roles");
    chk({p4_addr, p0_data, p1_data}, 3'h6, "8 bit data roles");
    chk(addr_valid, 1'b0, "addr not yet valid");
    for (int i = 0; i < 4; i++) begin
      acc(ta[i], 1'b0);
      chk(sel_n, ts[i], "mode 3 select");
      chk({~top_n, addr}, ta[i], "address lines");
    end
    chk(addr_valid, 1'b1, "addr valid after access");
    acc(24'h50_0000, 1'b0);
    chk(sel_n, 4'hE, "select held");
    chk({~top_n, addr}, 24'hE0_0000, "address held");
    chk(seen_addr, 24'hE0_0000, "device saw address");
    chk(seen_sel, 4'hE, "device saw select");
    done("mode3");
    cfg(2'h1, 2'h0, 2'h3, 4'h0);
    chk(p4_cs, 4'h7, "mode 1 pin roles");
    acc(24'h00_8000, 1'b0);
    chk(sel_n, 4'hD, "mode 1 low region");
    acc(24'hDF_FFFF, 1'b0);
    chk(sel_n, 4'hE, "mode 1 top region");
    cfg(2'h2, 2'h0, 2'h3, 4'h0);
    chk(p4_cs, 4'h3, "mode 2 pin roles");
    acc(24'h00_8000, 1'b0);
    acc(24'h20_0000, 1'b0);
    chk(sel_n, 4'hD, "mode 2 area 1 unmapped");
    done("mode1");
    cfg(2'h3, 2'h3, 2'h3, 4'h5);
    chk(width_o, 4'h5, "width bits");
    chk({p4_addr, p0_data, p1_data}, 3'h0, "all-space multiplex roles");
    acc(24'h12_3456, 1'b1);
    chk({~top_n, addr}, 24'h00_3456, "low 16 bits only");
    mode(2'h3);
    chk(fmt_o, 2'h0, "format forced separate");
    cfg(2'h3, 2'h3, 2'h3, 4'h5);
    chk(fmt_o, 2'h0, "format refused");
    acc(24'hF0_0000, 1'b0);
    chk(sel_n, 4'hE, "micro mode 3 top region");
    chk({~top_n, addr}, 24'hF0_0000, "micro address lines");
    done("format");
    mode(2'h1);
    cfg(2'h0, 2'h1, 2'h1, 4'h1);
    chk({p4_addr, p0_data, p1_data}, 3'h7, "16 bit data roles");
    acc(24'h00_8000, 1'b0);
    chk(ale, 3'h2, "latch strobe pin");
    chk({p2_mux, p3_mux}, 2'h3, "16 bit multiplexed");
    acc(24'hC0_0000, 1'b0);
    chk(p2_mux, 1'b0, "separate area address only");
    done("multiplex");
    @(posedge ref_clk);
    dram_en <= 1'b1;
    cfg(2'h0, 2'h0, 2'h3, 4'h4);
    acc(DA, 1'b1);
    chk(addr[20:8], DA[21:9], "row address");
    chk({dram_role, acc_ready}, 2'h2, "dram busy");
    @(posedge ref_clk);
    #1;
    chk(addr[20:8], {4'h0, DA[8:0]}, "column address");
    chk({cas_l, cas_h, dram_wr}, 3'h7, "column strobes");
    @(posedge ref_clk);
    #1;
    chk({dram_role, acc_ready, cas_l}, 3'h2, "dram done");
    done("dram");
    mode(2'h0);
    mode(2'h1);
    chk(addr_valid, 1'b0, "addr invalid after single chip");
    done("reentry");
    finish_test();
  end
endmodule
